// >>> design/pte_defines.vh
// register map, widths and encodings of the peripheral transfer engine
`ifndef PTE_DEFINES_VH
`define PTE_DEFINES_VH
`define PTE_NUM_CH 8
`define PTE_NUM_PERIPH 4
`define PTE_PTR_W 32
`define PTE_CNT_W 16
`define PTE_ADDR_W 32
`define PTE_WIN_W 14
`define PTE_WIN_MASK 32'hffffc000
`define PTE_WIN_LOW_W 14
`define PTE_TOP_LIMIT 32'hffd00000
`define PTE_BASE0 32'hfffc0000
`define PTE_BASE1 32'hfffc4000
`define PTE_BASE2 32'hfffc8000
`define PTE_BASE3 32'hfffbc000
`define PTE_OFF_RX_PTR 14'h0030
`define PTE_OFF_RX_CNT 14'h0034
`define PTE_OFF_TX_PTR 14'h0038
`define PTE_OFF_TX_CNT 14'h003c
`define PTE_OFF_IEN_SET 14'h0024
`define PTE_OFF_IEN_CLR 14'h0028
`define PTE_OFF_IEN_RD 14'h002c
`define PTE_OFF_STAT 14'h0014
`define PTE_STAT_RXEND 0
`define PTE_STAT_TXEND 1
`define PTE_IEN_W 2
`define PTE_SIZE_BYTE 2'h0
`define PTE_SIZE_HALF 2'h1
`define PTE_SIZE_WORD 2'h2
`define PTE_ST_IDLE 2'h0
`define PTE_ST_BUS 2'h1
`define PTE_ST_DONE 2'h2
`define PTE_ZERO_CNT 16'h0000
`define PTE_ZERO32 32'h00000000
`define PTE_ONE_CNT 16'h0001
`endif

// >>> design/pte_regdec.v
// address decode of one peripheral window onto its channel registers
`timescale 1ns/1ps
`include "pte_defines.vh"
module pte_regdec #(
    parameter [31:0] BASE = `PTE_BASE0
) (
    // register access
    input wire [31:0] addr,
    input wire sel,
    // decoded strobes
    output wire hit,
    output wire rx_ptr_sel,
    output wire rx_cnt_sel,
    output wire tx_ptr_sel,
    output wire tx_cnt_sel,
    output wire ien_set_sel,
    output wire ien_clr_sel,
    output wire ien_rd_sel,
    output wire stat_sel
);
    wire [13:0] off;
    // window is 16k bytes, base is its lowest address
    assign hit = sel && ((addr & `PTE_WIN_MASK) == BASE);
    assign off = addr[`PTE_WIN_LOW_W-1:0];
    assign rx_ptr_sel = hit && (off == `PTE_OFF_RX_PTR);
    assign rx_cnt_sel = hit && (off == `PTE_OFF_RX_CNT);
    assign tx_ptr_sel = hit && (off == `PTE_OFF_TX_PTR);
    assign tx_cnt_sel = hit && (off == `PTE_OFF_TX_CNT);
    assign ien_set_sel = hit && (off == `PTE_OFF_IEN_SET);
    assign ien_clr_sel = hit && (off == `PTE_OFF_IEN_CLR);
    assign ien_rd_sel = hit && (off == `PTE_OFF_IEN_RD);
    assign stat_sel = hit && (off == `PTE_OFF_STAT);
endmodule // pte_regdec

// >>> design/pte_channel.v
// one transfer channel: pointer, count, completion flag
`timescale 1ns/1ps
`include "pte_defines.vh"
module pte_channel (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // software programming
    input wire ptr_we,
    input wire cnt_we,
    input wire [31:0] wdata,
    // transfer progress
    input wire xfer_done,
    input wire [1:0] size,
    // state
    output reg [31:0] ptr_r,
    output reg [15:0] cnt_r,
    output wire active,
    output wire end_flag
);
    reg [2:0] step;
    always @* begin
        case (size)
            `PTE_SIZE_HALF: step = 3'h2;
            `PTE_SIZE_WORD: step = 3'h4;
            default: step = 3'h1;
        endcase
    end
    always @(posedge clk) begin
        if (!reset_n) begin
            ptr_r <= `PTE_ZERO32;
            cnt_r <= `PTE_ZERO_CNT;
        end else begin
            if (ptr_we)
                ptr_r <= wdata;
            else if (xfer_done)
                ptr_r <= ptr_r + {29'h0, step};
            if (cnt_we)
                cnt_r <= wdata[`PTE_CNT_W-1:0];
            else if (xfer_done && cnt_r != `PTE_ZERO_CNT)
                cnt_r <= cnt_r - `PTE_ONE_CNT;
        end
    end
    assign active = (cnt_r != `PTE_ZERO_CNT);
    assign end_flag = ~active;
endmodule // pte_channel

// >>> design/pte_engine.v
// eight-channel peripheral transfer engine with per-peripheral register windows
`timescale 1ns/1ps
`include "pte_defines.vh"
module pte_engine (
    // clock and reset
    input wire CORE_CLK,
    input wire RESET_N,
    // register access from the peripheral bus
    input wire REG_SEL,
    input wire REG_WRITE,
    input wire [31:0] REG_ADDR,
    input wire [31:0] REG_WDATA,
    output reg [31:0] REG_RDATA,
    output reg REG_HIT,
    // peripheral side, per-peripheral bits, size codes and data items; PER_TX_DATA shared, PER_END_STATUS one bit per channel
    input wire [3:0] PER_RX_READY,
    input wire [3:0] PER_TX_READY,
    input wire [63:0] PER_RX_DATA,
    input wire [7:0] PER_SIZE,
    output reg [3:0] PER_RX_ACK,
    output reg [3:0] PER_TX_WE,
    output reg [15:0] PER_TX_DATA,
    output reg [3:0] PER_END_IRQ,
    output reg [7:0] PER_END_STATUS,
    // memory bus master
    output reg MEM_REQ,
    output reg MEM_WRITE,
    output reg [31:0] MEM_ADDR,
    output reg [31:0] MEM_WDATA,
    output reg [3:0] MEM_BE,
    input wire MEM_READY,
    input wire [31:0] MEM_RDATA
);
    // engine states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_BUS = 2'h1;
    localparam [1:0] ST_DONE = 2'h2;
    reg [1:0] state_r, state_nxt;
    reg [2:0] cur_r;
    reg [1:0] size_r;
    reg [7:0] ien_r;
    wire [7:0] req;
    wire [7:0] act;
    wire [7:0] endf;
    wire [255:0] ptrs;
    wire [127:0] cnts;
    wire [7:0] ptr_we;
    wire [7:0] cnt_we;
    wire [3:0] hit;
    wire [3:0] ien_set, ien_clr, ien_rd, stat_rd;
    wire [7:0] done;
    reg [2:0] pick;
    reg pick_ok;
    wire [31:0] cur_ptr;
    integer k;
    integer j;
    integer m;
    wire [3:0] rx_ptr_hit;
    wire [3:0] rx_cnt_hit;
    wire [3:0] tx_ptr_hit;
    wire [3:0] tx_cnt_hit;
    wire [127:0] rd_word;
    wire [31:0] pick_ptr;
    wire [1:0] pick_size;
    wire [31:0] pick_wdata;

    // byte enables and lane placement for little-endian memory
    function [3:0] lane_be;
        input [1:0] sz;
        input [1:0] a;
        begin
            case (sz)
                `PTE_SIZE_WORD: lane_be = 4'hf;
                `PTE_SIZE_HALF: lane_be = a[1] ? 4'hc : 4'h3;
                default: lane_be = 4'h1 << a;
            endcase
        end
    endfunction

    // size code of the peripheral that a channel serves
    function [1:0] ch_size;
        input [7:0] sizes;
        input [2:0] ch;
        begin
            ch_size = sizes[2*ch[2:1] +: 2];
        end
    endfunction

    // little-endian: an item's low byte goes to the lane its address selects
    function [31:0] lane_data;
        input [15:0] item;
        input [1:0] a;
        begin
            lane_data = {item, item} << {a, 3'h0};
        end
    endfunction

    // memory word back down to an item, low byte from the addressed lane
    function [15:0] lane_item;
        input [31:0] word;
        input [1:0] a;
        reg [31:0] shifted;
        begin
            shifted = word >> {a, 3'h0};
            lane_item = shifted[15:0];
        end
    endfunction

    // channel 2p is receive, 2p+1 is transmit of peripheral p
    genvar p;
    generate
        for (p = 0; p < `PTE_NUM_PERIPH; p = p + 1) begin : g_per
            pte_regdec #(
                .BASE(p == 0 ? `PTE_BASE0 : p == 1 ? `PTE_BASE1 : p == 2 ? `PTE_BASE2 : `PTE_BASE3)
            ) u_dec (
                .addr(REG_ADDR),
                .sel(REG_SEL),
                .hit(hit[p]),
                .rx_ptr_sel(rx_ptr_hit[p]),
                .rx_cnt_sel(rx_cnt_hit[p]),
                .tx_ptr_sel(tx_ptr_hit[p]),
                .tx_cnt_sel(tx_cnt_hit[p]),
                .ien_set_sel(ien_set[p]),
                .ien_clr_sel(ien_clr[p]),
                .ien_rd_sel(ien_rd[p]),
                .stat_sel(stat_rd[p])
            );
            assign ptr_we[2*p] = REG_WRITE && rx_ptr_hit[p];
            assign cnt_we[2*p] = REG_WRITE && rx_cnt_hit[p];
            assign ptr_we[2*p+1] = REG_WRITE && tx_ptr_hit[p];
            assign cnt_we[2*p+1] = REG_WRITE && tx_cnt_hit[p];
            assign req[2*p] = PER_RX_READY[p] && act[2*p];
            assign req[2*p+1] = PER_TX_READY[p] && act[2*p+1];
            // read word of this window, zero where nothing readable is addressed
            assign rd_word[32*p +: 32] = rx_ptr_hit[p] ? ptrs[64*p +: 32] :
                rx_cnt_hit[p] ? {16'h0000, cnts[32*p +: 16]} :
                tx_ptr_hit[p] ? ptrs[64*p+32 +: 32] :
                tx_cnt_hit[p] ? {16'h0000, cnts[32*p+16 +: 16]} :
                ien_rd[p] ? {30'h0, ien_r[2*p +: 2]} :
                stat_rd[p] ? {30'h0, endf[2*p+1], endf[2*p]} :
                `PTE_ZERO32;
        end
    endgenerate

    genvar c;
    generate
        for (c = 0; c < `PTE_NUM_CH; c = c + 1) begin : g_ch
            assign done[c] = (state_r == ST_BUS) && MEM_READY && (cur_r == c);
            pte_channel u_ch (
                .clk(CORE_CLK),
                .reset_n(RESET_N),
                .ptr_we(ptr_we[c]),
                .cnt_we(cnt_we[c]),
                .wdata(REG_WDATA),
                .xfer_done(done[c]),
                .size(size_r),
                .ptr_r(ptrs[32*c+31:32*c]),
                .cnt_r(cnts[16*c+15:16*c]),
                .active(act[c]),
                .end_flag(endf[c])
            );
        end
    endgenerate

    assign cur_ptr = ptrs[32*cur_r +: 32];
    // pointer, size and lane-placed data of the channel about to be served
    assign pick_ptr = ptrs[32*pick +: 32];
    assign pick_size = ch_size(PER_SIZE, pick);
    assign pick_wdata = lane_data(PER_RX_DATA[16*pick[2:1] +: 16], pick_ptr[1:0]);

    // fixed priority, lowest channel first
    always @* begin
        pick = 3'h0;
        pick_ok = 1'b0;
        for (k = `PTE_NUM_CH - 1; k >= 0; k = k - 1) begin
            if (req[k]) begin
                pick = k[2:0];
                pick_ok = 1'b1;
            end
        end
    end

    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (pick_ok)
                    state_nxt = ST_BUS;
            end
            ST_BUS: begin
                if (MEM_READY)
                    state_nxt = ST_DONE;
            end
            // two idle cycles between transfers, ST_DONE then ST_IDLE
            ST_DONE: begin
                state_nxt = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // memory side transfer, no processor involvement
    always @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            state_r <= ST_IDLE;
            cur_r <= 3'h0;
            size_r <= `PTE_SIZE_BYTE;
            MEM_REQ <= 1'b0;
            MEM_WRITE <= 1'b0;
            MEM_ADDR <= `PTE_ZERO32;
            MEM_WDATA <= `PTE_ZERO32;
            MEM_BE <= 4'h0;
        end else begin
            state_r <= state_nxt;
            case (state_r)
                ST_IDLE: begin
                    // request, address, lanes and data stand until the memory answers
                    if (pick_ok) begin
                        cur_r <= pick;
                        size_r <= pick_size;
                        MEM_REQ <= 1'b1;
                        MEM_WRITE <= ~pick[0];
                        MEM_ADDR <= pick_ptr;
                        MEM_BE <= lane_be(pick_size, pick_ptr[1:0]);
                        MEM_WDATA <= pick_wdata;
                    end
                end
                ST_BUS: begin
                    if (MEM_READY)
                        MEM_REQ <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    // one-cycle strobes back to the served peripheral
    always @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            PER_RX_ACK <= 4'h0;
            PER_TX_WE <= 4'h0;
            PER_TX_DATA <= 16'h0000;
        end else begin
            PER_RX_ACK <= 4'h0;
            PER_TX_WE <= 4'h0;
            if (state_r == ST_BUS && MEM_READY) begin
                if (cur_r[0]) begin
                    PER_TX_WE[cur_r[2:1]] <= 1'b1;
                    PER_TX_DATA <= lane_item(MEM_RDATA, cur_ptr[1:0]);
                end else begin
                    PER_RX_ACK[cur_r[2:1]] <= 1'b1;
                end
            end
        end
    end

    // end-of-transfer enables with set, clear and read addresses
    always @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            ien_r <= 8'h00;
            PER_END_IRQ <= 4'h0;
            PER_END_STATUS <= 8'h00;
        end else begin
            for (j = 0; j < `PTE_NUM_PERIPH; j = j + 1) begin
                if (REG_WRITE && ien_set[j])
                    ien_r[2*j +: 2] <= ien_r[2*j +: 2] | REG_WDATA[`PTE_IEN_W-1:0];
                else if (REG_WRITE && ien_clr[j])
                    ien_r[2*j +: 2] <= ien_r[2*j +: 2] & ~REG_WDATA[`PTE_IEN_W-1:0];
                PER_END_IRQ[j] <= |(endf[2*j +: 2] & ien_r[2*j +: 2]);
            end
            PER_END_STATUS <= endf;
        end
    end

    // register read port, one cycle after the access, zero when nothing is hit
    always @(posedge CORE_CLK) begin
        if (!RESET_N) begin
            REG_RDATA <= `PTE_ZERO32;
            REG_HIT <= 1'b0;
        end else begin
            REG_HIT <= |hit;
            REG_RDATA <= `PTE_ZERO32;
            for (m = 0; m < `PTE_NUM_PERIPH; m = m + 1) begin
                if (!REG_WRITE && hit[m])
                    REG_RDATA <= rd_word[32*m +: 32];
            end
        end
    end
endmodule // pte_engine

// >>> verification/pte_engine_assertions.sv
// port assertions and covers for the transfer engine
`timescale 1ns/1ps
module pte_chk (
    // clock and reset
    input wire CORE_CLK,
    input wire RESET_N,
    // register side
    input wire REG_SEL,
    input wire REG_HIT,
    input wire [31:0] REG_RDATA,
    // peripheral side
    input wire [3:0] PER_RX_ACK,
    input wire [3:0] PER_TX_WE,
    input wire [3:0] PER_END_IRQ,
    input wire [7:0] PER_END_STATUS,
    // memory side
    input wire MEM_REQ,
    input wire MEM_WRITE,
    input wire [31:0] MEM_ADDR,
    input wire [3:0] MEM_BE,
    input wire MEM_READY
);
default clocking @(posedge CORE_CLK); endclocking
default disable iff (!RESET_N);
hit_needs_sel_a: assert property (REG_HIT |-> $past(REG_SEL)) else $error("hit without access");
rdata_idle_a: assert property (!$past(REG_SEL) |-> REG_RDATA == 32'h0) else $error("stray read data");
req_hold_a: assert property (MEM_REQ && !MEM_READY |=> MEM_REQ && $stable(MEM_ADDR))
    else $error("request dropped early");
req_gap_a: assert property (MEM_REQ && MEM_READY |=> !MEM_REQ) else $error("no idle after transfer");
ack_cause_a: assert property (|PER_RX_ACK |-> $past(MEM_REQ && MEM_READY && MEM_WRITE))
    else $error("ack without memory write");
txwe_cause_a: assert property (|PER_TX_WE |-> $past(MEM_REQ && MEM_READY && !MEM_WRITE))
    else $error("tx write without memory read");
one_xfer_a: assert property ($onehot0({PER_RX_ACK, PER_TX_WE})) else $error("two channels at once");
irq_status_a: assert property (PER_END_IRQ[0] |-> |PER_END_STATUS[1:0]) else $error("irq without end");
lanes_a: assert property (MEM_REQ |-> MEM_BE != 4'h0) else $error("no byte lane");
cover property (MEM_REQ && MEM_READY && MEM_WRITE);
cover property (MEM_REQ && MEM_READY && !MEM_WRITE);
cover property (REG_HIT);
cover property (|PER_END_IRQ);
endmodule // pte_chk
bind pte_engine pte_chk chk (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .REG_SEL(REG_SEL), .REG_HIT(REG_HIT),
    .REG_RDATA(REG_RDATA), .PER_RX_ACK(PER_RX_ACK), .PER_TX_WE(PER_TX_WE), .PER_END_IRQ(PER_END_IRQ),
    .PER_END_STATUS(PER_END_STATUS), .MEM_REQ(MEM_REQ), .MEM_WRITE(MEM_WRITE), .MEM_ADDR(MEM_ADDR),
    .MEM_BE(MEM_BE), .MEM_READY(MEM_READY));

// >>> verification/pte_mem_model.sv
// memory partner answering the engine's bus requests
`timescale 1ns/1ps
module pte_mem_model (
    // clock
    input wire clk,
    // request and latency
    input wire req,
    input wire [2:0] lat,
    // answer
    output reg ready,
    output reg [31:0] rdata
);
reg [2:0] wait_r = 3'h0;
initial begin
    ready = 1'b0;
    rdata = 32'h0;
end
always @(posedge clk) begin
    ready <= 1'b0;
    rdata <= ~rdata; // data is only good in the ready cycle
    if (req && !ready) begin
        if (wait_r >= lat) begin
            ready <= 1'b1;
            rdata <= 32'h44332211;
            wait_r <= 3'h0;
        end else begin
            wait_r <= wait_r + 3'h1;
        end
    end
end
endmodule // pte_mem_model

// >>> verification/tb_peripheral_data_transfer_ctrl.sv
// self-checking bench for the transfer engine
`timescale 1ns/1ps
`include "pte_defines.vh"
module tb_peripheral_data_transfer_ctrl;
reg clk = 1'b0;
reg rst_n = 1'b0;
reg sel = 1'b0;
reg wr = 1'b0;
reg [31:0] addr = 32'h0;
reg [31:0] wdata = 32'h0;
reg [3:0] rx_rdy = 4'h0;
reg [3:0] tx_rdy = 4'h0;
reg [63:0] rx_data = 64'hbeef;
reg [7:0] size = 8'h01;
reg [2:0] lat = 3'h0;
wire [31:0] rdata, m_addr, m_wdata, m_rdata;
wire hit, m_req, m_wr, m_rdy;
wire [3:0] rx_ack, tx_we, irq, m_be;
wire [15:0] tx_data;
wire [7:0] end_st;
integer error_cnt = 0;
integer checks = 0;
integer i;
localparam logic [31:0] B [4] = '{`PTE_BASE0, `PTE_BASE1, `PTE_BASE2, `PTE_BASE3};
always #50 clk = ~clk;
pte_engine dut (.CORE_CLK(clk), .RESET_N(rst_n), .REG_SEL(sel), .REG_WRITE(wr), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_HIT(hit), .PER_RX_READY(rx_rdy), .PER_TX_READY(tx_rdy),
    .PER_RX_DATA(rx_data), .PER_SIZE(size), .PER_RX_ACK(rx_ack), .PER_TX_WE(tx_we), .PER_TX_DATA(tx_data),
    .PER_END_IRQ(irq), .PER_END_STATUS(end_st), .MEM_REQ(m_req), .MEM_WRITE(m_wr), .MEM_ADDR(m_addr),
    .MEM_WDATA(m_wdata), .MEM_BE(m_be), .MEM_READY(m_rdy), .MEM_RDATA(m_rdata));
pte_mem_model mem (.clk(clk), .req(m_req), .lat(lat), .ready(m_rdy), .rdata(m_rdata));
task chk(input [31:0] got, input [31:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
endtask
task acc(input w, input [31:0] a, input [31:0] d);
    begin
        @(posedge clk);
        #1 sel = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        @(posedge clk);
        #1 sel = 1'b0;
    end
endtask
// waits for a completing memory cycle, checks it, then steps past it
task xfer(input w, input [31:0] a, input [3:0] be, input [31:0] d, input [31:0] m);
    integer k;
    begin
        k = 0;
        while (!(m_req === 1'b1 && m_rdy === 1'b1) && k < 40) begin
            @(posedge clk);
            #1 k = k + 1;
        end
        chk(m_wr, w);
        chk(m_addr, a);
        chk(m_be, be);
        chk(m_wdata & m, d);
        @(posedge clk);
        #1;
    end
endtask
task results;
    begin
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    end
endtask
initial begin
    #100000 error_cnt = error_cnt + 1;
    results;
end
initial begin
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    @(posedge clk);
    #1 chk(end_st, 8'hff);
    for (i = 0; i < 4; i = i + 1) begin
        acc(1'b1, B[i] + `PTE_OFF_RX_PTR, 32'hc0de0000 + i);
        acc(1'b1, B[i] + `PTE_OFF_TX_CNT, 32'hffff - i);
    end
    for (i = 0; i < 4; i = i + 1) begin
        acc(1'b0, B[i] + `PTE_OFF_RX_PTR, 32'h0);
        chk(rdata, 32'hc0de0000 + i);
        chk(hit, 1'b1);
        acc(1'b0, B[i] + `PTE_OFF_TX_CNT, 32'h0);
        chk(rdata, 32'hffff - i);
    end
    acc(1'b0, 32'hfffcc030, 32'h0);
    chk(rdata, 32'h0);
    chk(hit, 1'b0);
    $display("test map done");
    acc(1'b1, B[0] + `PTE_OFF_IEN_SET, 32'h3);
    acc(1'b1, B[0] + `PTE_OFF_IEN_CLR, 32'h1);
    acc(1'b1, B[0] + `PTE_OFF_IEN_SET, 32'h0);
    acc(1'b0, B[0] + `PTE_OFF_IEN_RD, 32'h0);
    chk(rdata, 32'h2);
    chk(irq, 4'h0);
    acc(1'b1, B[0] + `PTE_OFF_IEN_SET, 32'h1);
    @(posedge clk);
    #1 chk(irq[0], 1'b1);
    $display("test set clear done");
    acc(1'b1, B[0] + `PTE_OFF_RX_PTR, 32'h102);
    acc(1'b1, B[0] + `PTE_OFF_RX_CNT, 32'h2);
    rx_rdy = 4'h1;
    xfer(1'b1, 32'h102, 4'hc, 32'hbeef0000, 32'hffff0000);
    chk(rx_ack, 4'h1);
    xfer(1'b1, 32'h104, 4'h3, 32'h0000beef, 32'h0000ffff);
    repeat (4) @(posedge clk);
    #1 chk(m_req, 1'b0);
    chk(irq[0], 1'b1);
    acc(1'b0, B[0] + `PTE_OFF_RX_PTR, 32'h0);
    chk(rdata, 32'h106);
    rx_rdy = 4'h0;
    $display("test receive done");
    lat = 3'h3;
    size = 8'h00;
    acc(1'b1, B[1] + `PTE_OFF_TX_PTR, 32'h203);
    acc(1'b1, B[1] + `PTE_OFF_TX_CNT, 32'h1);
    tx_rdy = 4'h2;
    xfer(1'b0, 32'h203, 4'h8, 32'h0, 32'h0);
    chk(tx_we, 4'h2);
    chk(tx_data, 16'h0044);
    tx_rdy = 4'h0;
    @(posedge clk);
    #1 chk(end_st, 8'h5d);
    $display("test transmit done");
    results;
end
endmodule // tb_peripheral_data_transfer_ctrl
